/* include/ut_pkg.sv */
package ut_pkg;

   // bus geometry
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int AXI_STRB_W = 4;
   localparam int LANE_SHIFT = 3;

   // register offsets
   localparam logic [AXI_ADDR_W-1:0] PORT_CONTROL_OFFSET = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] QUEUE_IRQ_ENABLE_OFFSET = 8'h04;
   localparam logic [1:0] WORD_ALIGN = 2'h0;

   // port_control fields
   localparam int MULTI_PHY_BIT = 14;
   localparam int RX_COUNT_LSB = 2;
   localparam int RX_COUNT_W = 4;
   localparam int RX_ENABLE_BIT = 0;

   // queue_interrupt_enable fields
   localparam int RX_QIRQ_BIT = 16;
   localparam int TX_QIRQ_BIT = 0;

   // writable bits of each register
   localparam logic [31:0] PORT_CONTROL_MASK = 32'h0000_403d;
   localparam logic [31:0] QUEUE_IRQ_ENABLE_MASK = 32'h0001_0001;

   // reset values
   localparam logic MULTI_PHY_RESET = 1'b0;
   localparam logic [RX_COUNT_W-1:0] RX_COUNT_RESET = 4'h0;
   localparam logic RX_ENABLE_RESET = 1'b0;
   localparam logic RX_QIRQ_RESET = 1'b0;
   localparam logic TX_QIRQ_RESET = 1'b0;

   // cell lengths in bytes
   localparam int CELL_LEN_W = 7;
   localparam logic [CELL_LEN_W-1:0] BASE_CELL_LEN = 7'h35;
   localparam logic [CELL_LEN_W-1:0] MAX_CELL_LEN = 7'h40;
   localparam logic [RX_COUNT_W-1:0] MAX_EXTRA_HEADER = 4'hb;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} ut_wr_state_type;
   typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} ut_rd_state_type;

   typedef struct packed {
      logic awvalid;
      logic [AXI_ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [AXI_DATA_W-1:0] wdata;
      logic [AXI_STRB_W-1:0] wstrb;
      logic bready;
      logic arvalid;
      logic [AXI_ADDR_W-1:0] araddr;
      logic rready;
   } ut_axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } ut_axi_rsp_type;

   typedef struct packed {
      ut_wr_state_type wrState;
      logic awHave;
      logic [AXI_ADDR_W-1:0] awAddr;
      logic wHave;
      logic [AXI_DATA_W-1:0] wData;
      logic [AXI_STRB_W-1:0] wStrb;
      logic [1:0] bResp;
      ut_rd_state_type rdState;
      logic [AXI_DATA_W-1:0] rData;
      logic [1:0] rResp;
      logic awReady;
      logic wReady;
      logic arReady;
      logic multiPhy;
      logic [RX_COUNT_W-1:0] rxCount;
      logic rxEnable;
      logic rxQirqEn;
      logic txQirqEn;
   } ut_regs_state_type;

   typedef struct packed {
      logic holdReset;
      logic enabled;
      logic [CELL_LEN_W-1:0] cellLength;
   } ut_rx_state_type;

   typedef struct packed {
      logic pulse;
   } ut_irq_state_type;

endpackage

/* core/ut_rx_ctl.sv */
`timescale 1ns/10ps
module ut_rx_ctl (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // configuration
   input wire logic rxEnableBit,
   input wire logic [ut_pkg::RX_COUNT_W-1:0] rxCount,
   // receiver control
   output logic rxPortReset,
   output logic rxPortEnable,
   output logic [ut_pkg::CELL_LEN_W-1:0] rxCellLength
);

   ut_pkg::ut_rx_state_type st_reg;
   ut_pkg::ut_rx_state_type st_next;

   // expected cell length, reserved codes saturate
   function automatic logic [ut_pkg::CELL_LEN_W-1:0] cellLengthOf(
      input logic [ut_pkg::RX_COUNT_W-1:0] count);
      if (count > ut_pkg::MAX_EXTRA_HEADER) begin
         cellLengthOf = ut_pkg::MAX_CELL_LEN;
      end else begin
         cellLengthOf = ut_pkg::BASE_CELL_LEN + {3'h0, count};
      end
   endfunction

   always_comb begin
      st_next = st_reg;
      st_next.holdReset = !rxEnableBit;
      st_next.enabled = rxEnableBit;
      st_next.cellLength = cellLengthOf(rxCount);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '{holdReset: 1'b1, enabled: 1'b0, cellLength: ut_pkg::BASE_CELL_LEN};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rxPortReset = st_reg.holdReset;
   assign rxPortEnable = st_reg.enabled;
   assign rxCellLength = st_reg.cellLength;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_PLAIN_CELL: assert property (rxCount == 4'h0 |=> rxCellLength == 7'h35)
      else $error("zero count must give a 53 byte cell");
   AST_EXTRA_CELL: assert property (
      rxCount inside {[4'h1:4'hb]} |=> rxCellLength == 7'h35 + {3'h0, $past(rxCount)})
      else $error("extra header count not added to cell length");
   AST_HOLD_RESET: assert property (!rxEnableBit |=> rxPortReset && !rxPortEnable)
      else $error("receiver not held in reset while disabled");
   AST_RELEASE: assert property (rxEnableBit |=> !rxPortReset && rxPortEnable)
      else $error("receiver not released when enabled");
   COV_RELEASE: cover property (!rxEnableBit ##1 rxEnableBit ##1 rxPortEnable);
   COV_LONG_CELL: cover property (rxCellLength == 7'h40);

endmodule

/* core/ut_irq_gate.sv */
`timescale 1ns/10ps
module ut_irq_gate (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // queue events and enables
   input wire logic rxQueueEvent,
   input wire logic txQueueEvent,
   input wire logic rxQirqEn,
   input wire logic txQirqEn,
   // interrupt to selector
   output logic portInterrupt
);

   ut_pkg::ut_irq_state_type st_reg;
   ut_pkg::ut_irq_state_type st_next;

   always_comb begin
      st_next = st_reg;
      // high the cycle after any enabled event, one pulse when both come together
      st_next.pulse = (rxQueueEvent && rxQirqEn)
         || (txQueueEvent && txQirqEn);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '{pulse: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign portInterrupt = st_reg.pulse;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_RX_MASKED: assert property (
      !rxQirqEn && !(txQueueEvent && txQirqEn) |=> !portInterrupt)
      else $error("masked receive event raised the interrupt");
   AST_RX_ENABLED: assert property (rxQueueEvent && rxQirqEn |=> portInterrupt)
      else $error("enabled receive event gave no interrupt");
   AST_TX_MASKED: assert property (
      !txQirqEn && !(rxQueueEvent && rxQirqEn) |=> !portInterrupt)
      else $error("masked transmit event raised the interrupt");
   AST_TX_ENABLED: assert property (txQueueEvent && txQirqEn |=> portInterrupt)
      else $error("enabled transmit event gave no interrupt");
   AST_CAUSE: assert property (
      portInterrupt |-> $past(rxQueueEvent && rxQirqEn || txQueueEvent && txQirqEn))
      else $error("interrupt without an enabled event");
   COV_RX_IRQ: cover property (rxQueueEvent && rxQirqEn ##1 portInterrupt);
   COV_TX_IRQ: cover property (txQueueEvent && txQirqEn ##1 portInterrupt);

endmodule

/* core/ut_regs_top.sv */
// Overview of operation
// - multi-PHY bit clear selects single-PHY both directions; set selects multi-PHY
// - extra-header count zero: receiver expects a normal 53 byte cell
// - count one to eleven adds that many header bytes, cells 54 to 64
// - receive enable clear, the reset value, holds the receiver in reset
// - receive enable set releases the receiver and lets it run
// - receive queue interrupt enable clear: receive events raise no interrupt
// - receive queue interrupt enable set: each receive event raises the interrupt
// - transmit queue interrupt enable clear: transmit events raise no interrupt
// - transmit queue interrupt enable set: each transmit event raises the interrupt
// - reserved bits read zero and writes to them change nothing
`timescale 1ns/10ps
module ut_regs_top (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register bus
   input wire ut_pkg::ut_axi_req_type axiReq,
   output ut_pkg::ut_axi_rsp_type axiRsp,
   // queue events
   input wire logic rxQueueEvent,
   input wire logic txQueueEvent,
   // port configuration
   output logic multiPhySelect,
   output logic [ut_pkg::RX_COUNT_W-1:0] rxExtraHeaderCount,
   output logic [ut_pkg::CELL_LEN_W-1:0] rxCellLength,
   output logic rxPortReset,
   output logic rxPortEnable,
   // interrupt
   output logic portInterrupt
);

   localparam ut_pkg::ut_regs_state_type REGS_RESET = '{
      wrState: ut_pkg::WR_COLLECT,
      awHave: 1'b0,
      awAddr: 8'h00,
      wHave: 1'b0,
      wData: 32'h0000_0000,
      wStrb: 4'h0,
      bResp: ut_pkg::RESP_OKAY,
      rdState: ut_pkg::RD_IDLE,
      rData: 32'h0000_0000,
      rResp: ut_pkg::RESP_OKAY,
      awReady: 1'b1,
      wReady: 1'b1,
      arReady: 1'b1,
      multiPhy: ut_pkg::MULTI_PHY_RESET,
      rxCount: ut_pkg::RX_COUNT_RESET,
      rxEnable: ut_pkg::RX_ENABLE_RESET,
      rxQirqEn: ut_pkg::RX_QIRQ_RESET,
      txQirqEn: ut_pkg::TX_QIRQ_RESET
   };

   ut_pkg::ut_regs_state_type st_reg;
   ut_pkg::ut_regs_state_type st_next;

   // word-aligned form of a byte address
   function automatic logic [ut_pkg::AXI_ADDR_W-1:0] wordAddr(
      input logic [ut_pkg::AXI_ADDR_W-1:0] addr);
      wordAddr = {addr[ut_pkg::AXI_ADDR_W-1:2], ut_pkg::WORD_ALIGN};
   endfunction

   // address decode shared by write and read
   function automatic logic isMapped(
      input logic [ut_pkg::AXI_ADDR_W-1:0] addr);
      isMapped = (wordAddr(addr) == ut_pkg::PORT_CONTROL_OFFSET)
         || (wordAddr(addr) == ut_pkg::QUEUE_IRQ_ENABLE_OFFSET);
   endfunction

   // byte lane that carries a bit position
   function automatic logic laneOn(
      input logic [ut_pkg::AXI_STRB_W-1:0] strb,
      input int pos);
      laneOn = strb[pos >> ut_pkg::LANE_SHIFT];
   endfunction

   // single bit update under byte strobes
   function automatic logic wrBit(
      input logic oldBit,
      input logic [ut_pkg::AXI_DATA_W-1:0] data,
      input logic [ut_pkg::AXI_STRB_W-1:0] strb,
      input int pos);
      wrBit = laneOn(strb, pos) ? data[pos] : oldBit;
   endfunction

   // read data, reserved bits zero
   function automatic logic [ut_pkg::AXI_DATA_W-1:0] readWord(
      input ut_pkg::ut_regs_state_type s,
      input logic [ut_pkg::AXI_ADDR_W-1:0] addr);
      logic [ut_pkg::AXI_DATA_W-1:0] w;
      w = 32'h0000_0000;
      case (wordAddr(addr))
         ut_pkg::PORT_CONTROL_OFFSET: begin
            w[ut_pkg::MULTI_PHY_BIT] = s.multiPhy;
            w[ut_pkg::RX_COUNT_LSB +: ut_pkg::RX_COUNT_W] = s.rxCount;
            w[ut_pkg::RX_ENABLE_BIT] = s.rxEnable;
         end
         ut_pkg::QUEUE_IRQ_ENABLE_OFFSET: begin
            w[ut_pkg::RX_QIRQ_BIT] = s.rxQirqEn;
            w[ut_pkg::TX_QIRQ_BIT] = s.txQirqEn;
         end
         default: begin
            w = 32'h0000_0000;
         end
      endcase
      readWord = w;
   endfunction

   always_comb begin
      st_next = st_reg;

      // write channel
      case (st_reg.wrState)
         ut_pkg::WR_COLLECT: begin
            if (axiReq.awvalid && st_reg.awReady) begin
               st_next.awHave = 1'b1;
               st_next.awAddr = axiReq.awaddr;
            end
            if (axiReq.wvalid && st_reg.wReady) begin
               st_next.wHave = 1'b1;
               st_next.wData = axiReq.wdata;
               st_next.wStrb = axiReq.wstrb;
            end
            if (st_reg.awHave && st_reg.wHave) begin
               st_next.awHave = 1'b0;
               st_next.wHave = 1'b0;
               st_next.wrState = ut_pkg::WR_RESP;
               st_next.bResp = isMapped(st_reg.awAddr)
                  ? ut_pkg::RESP_OKAY : ut_pkg::RESP_SLVERR;
               // only the named fields take data
               case (wordAddr(st_reg.awAddr))
                  ut_pkg::PORT_CONTROL_OFFSET: begin
                     st_next.multiPhy = wrBit(st_reg.multiPhy, st_reg.wData,
                        st_reg.wStrb, ut_pkg::MULTI_PHY_BIT);
                     if (laneOn(st_reg.wStrb, ut_pkg::RX_COUNT_LSB)) begin
                        st_next.rxCount =
                           st_reg.wData[ut_pkg::RX_COUNT_LSB +: ut_pkg::RX_COUNT_W];
                     end
                     st_next.rxEnable = wrBit(st_reg.rxEnable, st_reg.wData,
                        st_reg.wStrb, ut_pkg::RX_ENABLE_BIT);
                  end
                  ut_pkg::QUEUE_IRQ_ENABLE_OFFSET: begin
                     st_next.rxQirqEn = wrBit(st_reg.rxQirqEn, st_reg.wData,
                        st_reg.wStrb, ut_pkg::RX_QIRQ_BIT);
                     st_next.txQirqEn = wrBit(st_reg.txQirqEn, st_reg.wData,
                        st_reg.wStrb, ut_pkg::TX_QIRQ_BIT);
                  end
                  default: begin
                     st_next.multiPhy = st_reg.multiPhy;
                  end
               endcase
            end
         end
         ut_pkg::WR_RESP: begin
            if (axiReq.bready) begin
               st_next.wrState = ut_pkg::WR_COLLECT;
            end
         end
         default: begin
            st_next.wrState = ut_pkg::WR_COLLECT;
         end
      endcase
      st_next.awReady = (st_next.wrState == ut_pkg::WR_COLLECT) && !st_next.awHave;
      st_next.wReady = (st_next.wrState == ut_pkg::WR_COLLECT) && !st_next.wHave;

      // read channel
      case (st_reg.rdState)
         ut_pkg::RD_IDLE: begin
            if (axiReq.arvalid && st_reg.arReady) begin
               st_next.rdState = ut_pkg::RD_DATA;
               st_next.rData = readWord(st_reg, axiReq.araddr);
               st_next.rResp = isMapped(axiReq.araddr)
                  ? ut_pkg::RESP_OKAY : ut_pkg::RESP_SLVERR;
            end
         end
         ut_pkg::RD_DATA: begin
            if (axiReq.rready) begin
               st_next.rdState = ut_pkg::RD_IDLE;
            end
         end
         default: begin
            st_next.rdState = ut_pkg::RD_IDLE;
         end
      endcase
      st_next.arReady = (st_next.rdState == ut_pkg::RD_IDLE);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= REGS_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // bus outputs
   assign axiRsp.awready = st_reg.awReady;
   assign axiRsp.wready = st_reg.wReady;
   assign axiRsp.bvalid = (st_reg.wrState == ut_pkg::WR_RESP);
   assign axiRsp.bresp = st_reg.bResp;
   assign axiRsp.arready = st_reg.arReady;
   assign axiRsp.rvalid = (st_reg.rdState == ut_pkg::RD_DATA);
   assign axiRsp.rdata = st_reg.rData;
   assign axiRsp.rresp = st_reg.rResp;

   // configuration outputs
   assign multiPhySelect = st_reg.multiPhy;
   assign rxExtraHeaderCount = st_reg.rxCount;

   // receiver reset and cell length
   ut_rx_ctl rxCtl (
      .clock(clock),
      .rst(rst),
      .rxEnableBit(st_reg.rxEnable),
      .rxCount(st_reg.rxCount),
      .rxPortReset(rxPortReset),
      .rxPortEnable(rxPortEnable),
      .rxCellLength(rxCellLength)
   );

   // queue event gating
   ut_irq_gate irqGate (
      .clock(clock),
      .rst(rst),
      .rxQueueEvent(rxQueueEvent),
      .txQueueEvent(txQueueEvent),
      .rxQirqEn(st_reg.rxQirqEn),
      .txQirqEn(st_reg.txQirqEn),
      .portInterrupt(portInterrupt)
   );

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic ctlWrite;
   logic irqWrite;
   assign ctlWrite = (st_reg.wrState == ut_pkg::WR_COLLECT) && st_reg.awHave
      && st_reg.wHave && (wordAddr(st_reg.awAddr) == ut_pkg::PORT_CONTROL_OFFSET);
   assign irqWrite = (st_reg.wrState == ut_pkg::WR_COLLECT) && st_reg.awHave
      && st_reg.wHave && (wordAddr(st_reg.awAddr) == ut_pkg::QUEUE_IRQ_ENABLE_OFFSET);

   AST_MULTI_PHY_SELECT_WRITE: assert property (
      ctlWrite && laneOn(st_reg.wStrb, ut_pkg::MULTI_PHY_BIT)
      |=> multiPhySelect == $past(st_reg.wData[ut_pkg::MULTI_PHY_BIT]))
      else $error("multi-PHY select did not follow the write");
   AST_MULTI_PHY_SELECT_KEEP: assert property (
      !ctlWrite |=> $stable(multiPhySelect))
      else $error("multi-PHY select changed without a write");
   AST_RSVD_READ: assert property (
      axiRsp.rvalid |-> (axiRsp.rdata
         & ~(ut_pkg::PORT_CONTROL_MASK | ut_pkg::QUEUE_IRQ_ENABLE_MASK)) == 32'h0)
      else $error("reserved bits read nonzero");
   AST_RSVD_WRITE: assert property (
      irqWrite && st_reg.wStrb == 4'hf && st_reg.wData == 32'hfffe_fffe
      |=> !st_reg.rxQirqEn && !st_reg.txQirqEn)
      else $error("reserved write changed an enable");
   AST_BRESP_AFTER: assert property (
      st_reg.awHave && st_reg.wHave |=> axiRsp.bvalid)
      else $error("write response missing");
   AST_B_HOLD: assert property (
      axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
      else $error("write response dropped before taken");
   AST_R_HOLD: assert property (
      axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
      else $error("read data dropped before taken");
   AST_R_ANSWER: assert property (
      axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
      else $error("read answer not one cycle after address");

   // per-field write and read strobes
   logic anyWrite;
   logic countWrite;
   logic enableWrite;
   logic rxQirqWrite;
   logic txQirqWrite;
   logic ctlRead;
   logic irqRead;
   assign anyWrite = (st_reg.wrState == ut_pkg::WR_COLLECT) && st_reg.awHave
      && st_reg.wHave;
   assign countWrite = ctlWrite && laneOn(st_reg.wStrb, ut_pkg::RX_COUNT_LSB);
   assign enableWrite = ctlWrite && laneOn(st_reg.wStrb, ut_pkg::RX_ENABLE_BIT);
   assign rxQirqWrite = irqWrite && laneOn(st_reg.wStrb, ut_pkg::RX_QIRQ_BIT);
   assign txQirqWrite = irqWrite && laneOn(st_reg.wStrb, ut_pkg::TX_QIRQ_BIT);
   assign ctlRead = axiReq.arvalid && axiRsp.arready
      && (wordAddr(axiReq.araddr) == ut_pkg::PORT_CONTROL_OFFSET);
   assign irqRead = axiReq.arvalid && axiRsp.arready
      && (wordAddr(axiReq.araddr) == ut_pkg::QUEUE_IRQ_ENABLE_OFFSET);

   AST_COUNT_WRITE: assert property (
      countWrite |=> rxExtraHeaderCount
         == $past(st_reg.wData[ut_pkg::RX_COUNT_LSB +: ut_pkg::RX_COUNT_W]))
      else $error("extra header count did not follow the write");
   AST_COUNT_KEEP: assert property (
      !countWrite |=> $stable(rxExtraHeaderCount))
      else $error("extra header count changed without a write");
   AST_ENABLE_WRITE: assert property (
      enableWrite |=> st_reg.rxEnable == $past(st_reg.wData[ut_pkg::RX_ENABLE_BIT]))
      else $error("receive enable did not follow the write");
   AST_ENABLE_KEEP: assert property (
      !enableWrite |=> $stable(st_reg.rxEnable))
      else $error("receive enable changed without a write");
   AST_RXQ_WRITE: assert property (
      rxQirqWrite |=> st_reg.rxQirqEn == $past(st_reg.wData[ut_pkg::RX_QIRQ_BIT]))
      else $error("receive queue enable did not follow the write");
   AST_RXQ_KEEP: assert property (
      !rxQirqWrite |=> $stable(st_reg.rxQirqEn))
      else $error("receive queue enable changed without a write");
   AST_TXQ_WRITE: assert property (
      txQirqWrite |=> st_reg.txQirqEn == $past(st_reg.wData[ut_pkg::TX_QIRQ_BIT]))
      else $error("transmit queue enable did not follow the write");
   AST_TXQ_KEEP: assert property (
      !txQirqWrite |=> $stable(st_reg.txQirqEn))
      else $error("transmit queue enable changed without a write");

   AST_BAD_WRITE: assert property (
      anyWrite && !isMapped(st_reg.awAddr) |=> axiRsp.bresp == ut_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");
   AST_GOOD_WRITE: assert property (
      anyWrite && isMapped(st_reg.awAddr) |=> axiRsp.bresp == ut_pkg::RESP_OKAY)
      else $error("mapped write refused");
   AST_BAD_READ: assert property (
      axiReq.arvalid && axiRsp.arready && !isMapped(axiReq.araddr)
      |=> axiRsp.rresp == ut_pkg::RESP_SLVERR && axiRsp.rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   AST_CTL_READ: assert property (
      ctlRead |=> axiRsp.rdata[ut_pkg::RX_COUNT_LSB +: ut_pkg::RX_COUNT_W]
         == $past(rxExtraHeaderCount) && axiRsp.rresp == ut_pkg::RESP_OKAY)
      else $error("control read does not match the stored count");
   AST_IRQ_READ: assert property (
      irqRead |=> axiRsp.rdata[ut_pkg::RX_QIRQ_BIT] == $past(st_reg.rxQirqEn)
         && axiRsp.rdata[ut_pkg::TX_QIRQ_BIT] == $past(st_reg.txQirqEn))
      else $error("enable read does not match the stored enables");
   AST_W_BLOCKED: assert property (
      axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
      else $error("write address or data open during the response");
   AST_AR_BLOCKED: assert property (
      axiRsp.rvalid |-> !axiRsp.arready)
      else $error("read address open during the answer");

   COV_CTL_WRITE: cover property (ctlWrite ##1 axiRsp.bvalid ##[1:4] axiReq.bready);
   COV_IRQ_WRITE: cover property (irqWrite ##1 axiRsp.bvalid);
   COV_READ: cover property (axiReq.arvalid && axiRsp.arready ##1 axiRsp.rvalid);
   COV_BAD_ADDR: cover property (axiRsp.bvalid && axiRsp.bresp == ut_pkg::RESP_SLVERR);
   COV_SLOW_READ: cover property (axiRsp.rvalid && !axiReq.rready ##1 axiReq.rready);

endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
   // clock and reset
   logic clock;
   logic rst;
   // register bus
   ut_pkg::ut_axi_req_type axiReq;
   ut_pkg::ut_axi_rsp_type axiRsp;
   // events and outputs
   logic rxQueueEvent;
   logic txQueueEvent;
   logic multiPhySelect;
   logic [3:0] rxExtraHeaderCount;
   logic [6:0] rxCellLength;
   logic rxPortReset;
   logic rxPortEnable;
   logic portInterrupt;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [1:0] rp;
   logic [31:0] v;
   logic [31:0] old;
   logic [31:0] r;
   logic prevExp;

   ut_regs_top i_dut (
      .clock(clock),
      .rst(rst),
      .axiReq(axiReq),
      .axiRsp(axiRsp),
      .rxQueueEvent(rxQueueEvent),
      .txQueueEvent(txQueueEvent),
      .multiPhySelect(multiPhySelect),
      .rxExtraHeaderCount(rxExtraHeaderCount),
      .rxCellLength(rxCellLength),
      .rxPortReset(rxPortReset),
      .rxPortEnable(rxPortEnable),
      .portInterrupt(portInterrupt)
   );

   // expected receive cell length
   function automatic logic [6:0] cell_len(input logic [3:0] c);
      return (c > 4'hb) ? 7'h40 : 7'h35 + {3'h0, c};
   endfunction

   task automatic tally_and_finish();
      if (num_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] er);
      logic aw;
      logic w;
      logic b;
      logic [31:0] pick;
      aw = 1'b0;
      w = 1'b0;
      b = 1'b0;
      pick = $urandom;
      @(posedge clock);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= s;
      axiReq.bready <= pick[0];
      while (!b) begin
         @(posedge clock);
         if (axiRsp.bvalid && axiReq.bready) begin
            b = 1'b1;
            axiReq.bready <= 1'b0;
            `CHK(axiRsp.bresp, er)
         end else if (axiRsp.bvalid) begin
            axiReq.bready <= 1'b1;
         end
         if (!aw && axiRsp.awready) begin
            aw = 1'b1;
            axiReq.awvalid <= 1'b0;
         end
         if (!w && axiRsp.wready) begin
            w = 1'b1;
            axiReq.wvalid <= 1'b0;
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
      logic ar;
      logic done;
      logic [31:0] pick;
      ar = 1'b0;
      done = 1'b0;
      pick = $urandom;
      @(posedge clock);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= pick[0];
      while (!done) begin
         @(posedge clock);
         if (axiRsp.rvalid && axiReq.rready) begin
            done = 1'b1;
            d = axiRsp.rdata;
            e = axiRsp.rresp;
            axiReq.rready <= 1'b0;
         end else if (axiRsp.rvalid) begin
            axiReq.rready <= 1'b1;
         end
         if (!ar && axiRsp.arready) begin
            ar = 1'b1;
            axiReq.arvalid <= 1'b0;
         end
      end
   endtask

   // outputs in their reset state
   task automatic check_reset_state();
      @(negedge clock);
      `CHK(multiPhySelect, 1'b0)
      `CHK(rxExtraHeaderCount, 4'h0)
      `CHK(rxCellLength, 7'h35)
      `CHK(rxPortReset, 1'b1)
      `CHK(rxPortEnable, 1'b0)
      `CHK(portInterrupt, 1'b0)
      axi_read(ut_pkg::PORT_CONTROL_OFFSET, rd, rp);
      `CHK(rd, 32'h0)
      axi_read(ut_pkg::QUEUE_IRQ_ENABLE_OFFSET, rd, rp);
      `CHK(rd, 32'h0)
   endtask

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   initial begin
      rst = 1'b1;
      axiReq = '0;
      rxQueueEvent = 1'b0;
      txQueueEvent = 1'b0;
      void'($urandom(98660));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      check_reset_state();
      // every legal count with random reserved and mode bits
      for (int c = 0; c < 12; c++) begin
         v = $urandom;
         v[5:2] = c[3:0];
         axi_write(ut_pkg::PORT_CONTROL_OFFSET, v, 4'hf, 2'h0);
         @(negedge clock);
         `CHK(multiPhySelect, v[14])
         `CHK(rxExtraHeaderCount, c[3:0])
         `CHK(rxCellLength, cell_len(c[3:0]))
         `CHK(rxPortEnable, v[0])
         `CHK(rxPortReset, ~v[0])
         axi_read(ut_pkg::PORT_CONTROL_OFFSET, rd, rp);
         `CHK(rd, v & 32'h0000_403d)
         `CHK(rp, 2'h0)
      end
      // lane 0 off leaves count and enable alone
      old = v & 32'h0000_403d;
      v = $urandom;
      axi_write(ut_pkg::PORT_CONTROL_OFFSET, v, 4'he, 2'h0);
      axi_read(ut_pkg::PORT_CONTROL_OFFSET, rd, rp);
      `CHK(rd, (old & 32'h0000_00ff) | (v & 32'h0000_4000))
      // unmapped word and ignored low address bits
      axi_write(8'h08, $urandom, 4'hf, 2'h2);
      axi_read(8'h08, rd, rp);
      `CHK(rd, 32'h0)
      `CHK(rp, 2'h2)
      axi_read(8'h02, rd, rp);
      `CHK(rd, (old & 32'h0000_00ff) | (v & 32'h0000_4000))
      // each enable combination against random events
      for (int e = 0; e < 4; e++) begin
         v = (e >= 2) ? 32'h0 : $urandom;
         v[16] = e[1];
         v[0] = e[0];
         axi_write(ut_pkg::QUEUE_IRQ_ENABLE_OFFSET, v, 4'hf, 2'h0);
         axi_read(ut_pkg::QUEUE_IRQ_ENABLE_OFFSET, rd, rp);
         `CHK(rd, v & 32'h0001_0001)
         prevExp = 1'b0;
         repeat (24) begin
            @(posedge clock);
            r = $urandom;
            rxQueueEvent <= r[0];
            txQueueEvent <= r[1];
            @(negedge clock);
            `CHK(portInterrupt, prevExp)
            prevExp = (r[0] & e[1]) | (r[1] & e[0]);
         end
         @(posedge clock);
         rxQueueEvent <= 1'b0;
         txQueueEvent <= 1'b0;
         @(negedge clock);
         `CHK(portInterrupt, prevExp)
      end
      // reserved bits all set clears both enables
      axi_write(ut_pkg::QUEUE_IRQ_ENABLE_OFFSET, 32'hfffe_fffe, 4'hf, 2'h0);
      axi_read(ut_pkg::QUEUE_IRQ_ENABLE_OFFSET, rd, rp);
      `CHK(rd, 32'h0)
      // reset in mid-run with the receive event on
      @(posedge clock);
      rst <= 1'b1;
      rxQueueEvent <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rxQueueEvent <= 1'b0;
      check_reset_state();
      tally_and_finish();
   end
endmodule
